// ### rtl/dpio_top.sv
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dpio_cfg.svh"

// How it works
// - First port six or eight pins wide
// - Second port optional, medium and large only
// - Direction 0 drives latch, 1 input
// - Peripheral may force pin direction
// - Forced direction never stored in register
// - Open-drain select for capture and serial
// - Analog select leaves output path alone
// - Analog blocks digital input on listed pins
// - Analog pins reset analog, direction input
// - Segment enable disconnects all other functions
// - Common enable overrides outputs, bits 0-3
// - Clock output overrides first-port bit 4
// - External bus drives upper address bits
module dpio_top import dpio_pkg::*; #(
  parameter int PKG_VARIANT = 2
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // First port pads
  input  wire logic [7:0]  first_pad_in,
  output logic      [7:0]  first_pad_out,
  output logic      [7:0]  first_pad_oe_n,
  // Second port pads
  input  wire logic [7:0]  second_pad_in,
  output logic      [7:0]  second_pad_out,
  output logic      [7:0]  second_pad_oe_n,
  // Digital inputs to peripherals
  output logic      [7:0]  first_dig_in,
  output logic      [7:0]  second_dig_in,
  // First port peripheral requests
  input  wire logic [7:0]  first_ccp_out_en,
  input  wire logic [7:0]  first_serial_out_en,
  input  wire logic [7:0]  first_other_out_en,
  input  wire logic [7:0]  first_periph_out,
  input  wire logic [7:0]  first_periph_in_force,
  // Second port peripheral requests
  input  wire logic [7:0]  second_periph_out_en,
  input  wire logic [7:0]  second_periph_out,
  input  wire logic [7:0]  second_periph_in_force,
  // LCD controller
  input  wire logic [7:0]  first_lcd_seg_en,
  input  wire logic [7:0]  first_lcd_seg_val,
  input  wire logic [7:0]  first_lcd_com_en,
  input  wire logic [7:0]  first_lcd_com_val,
  input  wire logic [7:0]  second_lcd_seg_en,
  input  wire logic [7:0]  second_lcd_seg_val,
  // Clock output and external bus
  input  wire logic        clock_calendar_output,
  input  wire logic [3:0]  ext_bus_upper_address
);

  localparam logic [7:0] FIRST_IMPL = (PKG_VARIANT == `DPIO_VARIANT_LARGE) ?
                                      `DPIO_FULL_MASK : `DPIO_FIRST_SMALL_MASK;
  // second port left out on small parts
  localparam logic [7:0] SECOND_IMPL = (PKG_VARIANT == `DPIO_VARIANT_SMALL) ?
                                       `DPIO_NONE_MASK : `DPIO_FULL_MASK;

  // Software state
  logic [7:0]      first_port_latch;
  logic [7:0]      first_port_direction;
  logic [7:0]      second_port_latch;
  logic [7:0]      second_port_direction;
  logic [15:0]     analog_select_reg;
  logic [3:0]      ctrl;
  dpio_apb_state_t state;

  logic [7:0]      next_first_port_latch;
  logic [7:0]      next_first_port_direction;
  logic [7:0]      next_second_port_latch;
  logic [7:0]      next_second_port_direction;
  logic [15:0]     next_analog_select_reg;
  logic [3:0]      next_ctrl;
  dpio_apb_state_t next_state;
  logic [31:0]     next_prdata;
  logic            next_pready;
  logic            next_pslverr;

  // Pin side
  logic [7:0]      first_sync;
  logic [7:0]      second_sync;
  dpio_pin_ctl_t   first_ctl;
  dpio_pin_ctl_t   second_ctl;
  logic            write_fire;

  // Address decode, shared by read, write and error
  function automatic logic reg_hit(input logic [7:0] addr);
    case (addr)
      `DPIO_OFF_FIRST_LATCH,
      `DPIO_OFF_FIRST_DIR,
      `DPIO_OFF_FIRST_DATA,
      `DPIO_OFF_ANALOG,
      `DPIO_OFF_CTRL:        reg_hit = 1'b1;
      `DPIO_OFF_SECOND_LATCH,
      `DPIO_OFF_SECOND_DIR,
      `DPIO_OFF_SECOND_DATA: reg_hit = (SECOND_IMPL != `DPIO_NONE_MASK);
      default:               reg_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] addr);
    rd_word = `DPIO_ZERO_WORD;
    case (addr)
      `DPIO_OFF_FIRST_LATCH:  rd_word[7:0]  = first_port_latch;
      `DPIO_OFF_FIRST_DIR:    rd_word[7:0]  = first_port_direction;
      `DPIO_OFF_FIRST_DATA:   rd_word[7:0]  = first_dig_in;
      `DPIO_OFF_SECOND_LATCH: rd_word[7:0]  = second_port_latch;
      `DPIO_OFF_SECOND_DIR:   rd_word[7:0]  = second_port_direction;
      `DPIO_OFF_SECOND_DATA:  rd_word[7:0]  = second_dig_in;
      `DPIO_OFF_ANALOG:       rd_word[15:0] = analog_select_reg;
      `DPIO_OFF_CTRL:         rd_word[3:0]  = ctrl;
      default:                rd_word       = `DPIO_ZERO_WORD;
    endcase
    if (!reg_hit(addr)) begin
      rd_word = `DPIO_ZERO_WORD;
    end
  endfunction

  // Transfer commits only at the edge that samples pready
  assign write_fire = (state == DPIO_ANSWER) && psel && penable && pwrite &&
                      reg_hit(paddr);

  // APB handshake: pready one cycle into the access phase
  always_comb begin
    next_state   = state;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    case (state)
      DPIO_IDLE: begin
        if (psel) begin
          next_state = DPIO_ACCESS;
        end
      end
      DPIO_ACCESS: begin
        if (psel && penable) begin
          next_state   = DPIO_ANSWER;
          next_pready  = 1'b1;
          next_pslverr = !reg_hit(paddr);
          next_prdata  = pwrite ? `DPIO_ZERO_WORD : rd_word(paddr);
        end else if (!psel) begin
          next_state = DPIO_IDLE;
        end
      end
      DPIO_ANSWER: begin
        next_state = DPIO_IDLE;
      end
      default: begin
        next_state = DPIO_IDLE;
      end
    endcase
  end

  // Register writes
  always_comb begin
    next_first_port_latch      = first_port_latch;
    next_first_port_direction  = first_port_direction;
    next_second_port_latch     = second_port_latch;
    next_second_port_direction = second_port_direction;
    next_analog_select_reg     = analog_select_reg;
    next_ctrl                  = ctrl;
    if (write_fire) begin
      case (paddr)
        `DPIO_OFF_FIRST_LATCH,
        `DPIO_OFF_FIRST_DATA: begin
          next_first_port_latch = pwdata[7:0] & FIRST_IMPL;
        end
        `DPIO_OFF_FIRST_DIR: begin
          next_first_port_direction = pwdata[7:0] & FIRST_IMPL;
        end
        `DPIO_OFF_SECOND_LATCH,
        `DPIO_OFF_SECOND_DATA: begin
          next_second_port_latch = pwdata[7:0] & SECOND_IMPL;
        end
        `DPIO_OFF_SECOND_DIR: begin
          next_second_port_direction = pwdata[7:0] & SECOND_IMPL;
        end
        `DPIO_OFF_ANALOG: begin
          next_analog_select_reg = {pwdata[15:8] & SECOND_IMPL,
                                    pwdata[7:0] & FIRST_IMPL & `DPIO_FIRST_AN_MASK};
        end
        `DPIO_OFF_CTRL: begin
          next_ctrl = pwdata[3:0];
        end
        default: begin
          next_ctrl = ctrl;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                 <= DPIO_IDLE;
      prdata                <= `DPIO_ZERO_WORD;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      first_port_latch      <= `DPIO_LATCH_RESET;
      second_port_latch     <= `DPIO_LATCH_RESET;
      first_port_direction  <= `DPIO_DIR_RESET & FIRST_IMPL;
      second_port_direction <= `DPIO_DIR_RESET & SECOND_IMPL;
      analog_select_reg     <= {`DPIO_SECOND_AN_RESET & SECOND_IMPL,
                                `DPIO_FIRST_AN_RESET & FIRST_IMPL};
      ctrl                  <= `DPIO_CTRL_RESET;
    end else begin
      state                 <= next_state;
      prdata                <= next_prdata;
      pready                <= next_pready;
      pslverr               <= next_pslverr;
      first_port_latch      <= next_first_port_latch;
      first_port_direction  <= next_first_port_direction;
      second_port_latch     <= next_second_port_latch;
      second_port_direction <= next_second_port_direction;
      analog_select_reg     <= next_analog_select_reg;
      ctrl                  <= next_ctrl;
    end
  end

  // Pads come from outside the clock domain
  dpio_sync #(.W(8)) u_first_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (first_pad_in),
    .sync_out (first_sync)
  );

  dpio_sync #(.W(8)) u_second_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (second_pad_in),
    .sync_out (second_sync)
  );

  // Pin control assembly
  always_comb begin
    first_ctl.latch           = first_port_latch;
    first_ctl.dir             = first_port_direction;
    first_ctl.analog_sel      = analog_select_reg[7:0];
    first_ctl.od_sel          = (first_ccp_out_en & {8{ctrl[`DPIO_CTRL_OD_CCP]}}) |
                                (first_serial_out_en & {8{ctrl[`DPIO_CTRL_OD_SERIAL]}});
    first_ctl.alt_en          = '0;
    first_ctl.alt_val         = '0;
    first_ctl.alt_en[`DPIO_RTC_PIN]  = ctrl[`DPIO_CTRL_RTC_EN];
    first_ctl.alt_val[`DPIO_RTC_PIN] = clock_calendar_output;
    first_ctl.periph_out_en   = first_ccp_out_en | first_serial_out_en |
                                first_other_out_en;
    first_ctl.periph_out      = first_periph_out;
    first_ctl.periph_in_force = first_periph_in_force;
    first_ctl.lcd_seg_en      = first_lcd_seg_en;
    first_ctl.lcd_seg_val     = first_lcd_seg_val;
    first_ctl.lcd_com_en      = first_lcd_com_en & `DPIO_FIRST_COM_MASK;
    first_ctl.lcd_com_val     = first_lcd_com_val;

    second_ctl.latch           = second_port_latch;
    second_ctl.dir             = second_port_direction;
    second_ctl.analog_sel      = analog_select_reg[15:8];
    second_ctl.od_sel          = '0;
    second_ctl.alt_en          = {8{ctrl[`DPIO_CTRL_EXT_BUS_EN]}} & `DPIO_EXT_BUS_MASK;
    second_ctl.alt_val         = {4'h0, ext_bus_upper_address};
    second_ctl.periph_out_en   = second_periph_out_en;
    second_ctl.periph_out      = second_periph_out;
    second_ctl.periph_in_force = second_periph_in_force;
    second_ctl.lcd_seg_en      = second_lcd_seg_en;
    second_ctl.lcd_seg_val     = second_lcd_seg_val;
    second_ctl.lcd_com_en      = '0;
    second_ctl.lcd_com_val     = '0;
  end

  // first port blocks on every pin
  dpio_pin_mux #(.IMPL(FIRST_IMPL), .BLOCK(`DPIO_FULL_MASK)) u_first_mux (
    .pclk     (pclk),
    .presetn  (presetn),
    .ctl      (first_ctl),
    .pad_sync (first_sync),
    .pad_out  (first_pad_out),
    .pad_oe_n (first_pad_oe_n),
    .dig_in   (first_dig_in)
  );

  // zero mask trims this instance away
  dpio_pin_mux #(.IMPL(SECOND_IMPL), .BLOCK(`DPIO_SECOND_BLK_MASK)) u_second_mux (
    .pclk     (pclk),
    .presetn  (presetn),
    .ctl      (second_ctl),
    .pad_sync (second_sync),
    .pad_out  (second_pad_out),
    .pad_oe_n (second_pad_oe_n),
    .dig_in   (second_dig_in)
  );

endmodule

`default_nettype wire

// ### rtl/dpio_cfg.svh
`ifndef DPIO_CFG_SVH
`define DPIO_CFG_SVH

// Register byte offsets
`define DPIO_OFF_FIRST_LATCH  8'h00
`define DPIO_OFF_FIRST_DIR    8'h04
`define DPIO_OFF_FIRST_DATA   8'h08
`define DPIO_OFF_SECOND_LATCH 8'h0C
`define DPIO_OFF_SECOND_DIR   8'h10
`define DPIO_OFF_SECOND_DATA  8'h14
`define DPIO_OFF_ANALOG       8'h18
`define DPIO_OFF_CTRL         8'h1C

// Reset values
`define DPIO_LATCH_RESET      8'h00
`define DPIO_DIR_RESET        8'hFF
`define DPIO_FIRST_AN_RESET   8'h1F
`define DPIO_SECOND_AN_RESET  8'hFF
`define DPIO_CTRL_RESET       4'h0
`define DPIO_ZERO_WORD        32'h0000_0000

// Pin masks
`define DPIO_FIRST_SMALL_MASK 8'h3F
`define DPIO_FULL_MASK        8'hFF
`define DPIO_NONE_MASK        8'h00
`define DPIO_FIRST_AN_MASK    8'h1F
`define DPIO_SECOND_BLK_MASK  8'hF0
`define DPIO_FIRST_COM_MASK   8'h0F
`define DPIO_EXT_BUS_MASK     8'h0F
`define DPIO_RTC_PIN          4

// Control register fields
`define DPIO_CTRL_OD_CCP      0
`define DPIO_CTRL_OD_SERIAL   1
`define DPIO_CTRL_RTC_EN      2
`define DPIO_CTRL_EXT_BUS_EN  3

// Package variants
`define DPIO_VARIANT_SMALL    0
`define DPIO_VARIANT_LARGE    2

`endif

// ### rtl/dpio_pkg.sv
`default_nettype none

package dpio_pkg;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] analog_sel;
    logic [7:0] od_sel;
    logic [7:0] alt_en;
    logic [7:0] alt_val;
    logic [7:0] periph_out_en;
    logic [7:0] periph_out;
    logic [7:0] periph_in_force;
    logic [7:0] lcd_seg_en;
    logic [7:0] lcd_seg_val;
    logic [7:0] lcd_com_en;
    logic [7:0] lcd_com_val;
  } dpio_pin_ctl_t;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] val;
  } dpio_drive_t;

  typedef enum logic [1:0] {
    DPIO_IDLE   = 2'b00,
    DPIO_ACCESS = 2'b01,
    DPIO_ANSWER = 2'b11
  } dpio_apb_state_t;

endpackage

`default_nettype wire

// ### rtl/dpio_sync.sv
`timescale 1ns/10ps
`default_nettype none

module dpio_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // First stage is read by the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

`default_nettype wire

// ### rtl/dpio_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpio_cfg.svh"

module dpio_pin_mux import dpio_pkg::*; #(
  parameter logic [7:0] IMPL  = 8'hFF,
  parameter logic [7:0] BLOCK = 8'hFF
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Control and pads
  input  wire dpio_pin_ctl_t ctl,
  input  wire logic [7:0]    pad_sync,
  output logic      [7:0]    pad_out,
  output logic      [7:0]    pad_oe_n,
  output logic      [7:0]    dig_in
);

  logic [7:0] next_pad_out;
  logic [7:0] next_pad_oe_n;
  logic [7:0] next_dig_in;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      next_pad_out[i]  = 1'b0;
      next_pad_oe_n[i] = 1'b1;
      if (!IMPL[i]) begin
        next_pad_oe_n[i] = 1'b1;
      end else if (ctl.lcd_seg_en[i]) begin
        next_pad_out[i]  = ctl.lcd_seg_val[i];
        next_pad_oe_n[i] = 1'b0;
      end else if (ctl.lcd_com_en[i]) begin
        next_pad_out[i]  = ctl.lcd_com_val[i];
        next_pad_oe_n[i] = 1'b0;
      end else if (ctl.alt_en[i]) begin
        next_pad_out[i]  = ctl.alt_val[i];
        next_pad_oe_n[i] = 1'b0;
      end else if (ctl.periph_out_en[i]) begin
        if (ctl.od_sel[i]) begin
          next_pad_oe_n[i] = ctl.periph_out[i];
        end else begin
          next_pad_out[i]  = ctl.periph_out[i];
          next_pad_oe_n[i] = 1'b0;
        end
      end else if (ctl.periph_in_force[i]) begin
        next_pad_oe_n[i] = 1'b1;
      end else if (!ctl.dir[i]) begin
        next_pad_out[i]  = ctl.latch[i];
        next_pad_oe_n[i] = 1'b0;
      end
    end
    next_dig_in = pad_sync & IMPL & ~(ctl.analog_sel & BLOCK) & ~ctl.lcd_seg_en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out  <= 8'h00;
      pad_oe_n <= 8'hFF;
      dig_in   <= 8'h00;
    end else begin
      pad_out  <= next_pad_out;
      pad_oe_n <= next_pad_oe_n;
      dig_in   <= next_dig_in;
    end
  end

endmodule

`default_nettype wire

// ### verification/dpio_top_properties.sv
`timescale 1ns/10ps
`default_nettype none

module dpio_top_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pads
  input wire logic [7:0]  first_pad_out,
  input wire logic [7:0]  first_pad_oe_n,
  input wire logic [7:0]  second_pad_oe_n,
  input wire logic [7:0]  first_dig_in,
  // Peripherals and LCD
  input wire logic [7:0]  first_ccp_out_en,
  input wire logic [7:0]  first_serial_out_en,
  input wire logic [7:0]  first_other_out_en,
  input wire logic [7:0]  first_periph_out,
  input wire logic [7:0]  first_periph_in_force,
  input wire logic [7:0]  first_lcd_seg_en,
  input wire logic [7:0]  first_lcd_seg_val,
  input wire logic [7:0]  first_lcd_com_en,
  input wire logic [7:0]  first_lcd_com_val
);
  logic [7:0] com_mask;
  logic [7:0] oth_mask;
  logic [7:0] inf_mask;

  // Common check on bits 0-3 only; other and forced-input checks on upper bits, so no common or clock override interferes
  assign com_mask = first_lcd_com_en & ~first_lcd_seg_en & 8'h0F;
  assign oth_mask = first_other_out_en & ~first_lcd_seg_en & 8'hE0;
  assign inf_mask = first_periph_in_force & ~first_lcd_seg_en & ~first_other_out_en
                    & ~first_ccp_out_en & ~first_serial_out_en & 8'hE0;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && !pready;
  endsequence

  property p_ready_after_wait;
    s_setup ##1 s_access |=> pready;
  endproperty
  a_ready_after_wait: assert property (p_ready_after_wait) else $error("pready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_unmapped;
    s_access and (paddr > 8'h1C) |=> pslverr && (prdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_reset_idle;
    $rose(presetn) |-> (first_pad_oe_n == 8'hFF) && (second_pad_oe_n == 8'hFF) && !pready;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pads driven at reset");
  property p_seg_blocks_in;
    ($stable(first_lcd_seg_en) && first_lcd_seg_en != 8'h00) [*2]
      |-> (first_dig_in & first_lcd_seg_en) == 8'h00;
  endproperty
  a_seg_blocks_in: assert property (p_seg_blocks_in) else $error("segment input seen");
  property p_seg_drive;
    (first_lcd_seg_en != 8'h00) |=> ((first_pad_oe_n & $past(first_lcd_seg_en)) == 8'h00)
      && (((first_pad_out ^ $past(first_lcd_seg_val)) & $past(first_lcd_seg_en)) == 8'h00);
  endproperty
  a_seg_drive: assert property (p_seg_drive) else $error("segment not driven");
  property p_com_drive;
    (com_mask != 8'h00) |=> ((first_pad_oe_n & $past(com_mask)) == 8'h00)
      && (((first_pad_out ^ $past(first_lcd_com_val)) & $past(com_mask)) == 8'h00);
  endproperty
  a_com_drive: assert property (p_com_drive) else $error("common not driven");
  property p_other_drive;
    (oth_mask != 8'h00) |=> ((first_pad_oe_n & $past(oth_mask)) == 8'h00)
      && (((first_pad_out ^ $past(first_periph_out)) & $past(oth_mask)) == 8'h00);
  endproperty
  a_other_drive: assert property (p_other_drive) else $error("forced output lost");
  property p_in_force;
    (inf_mask != 8'h00) |=> (first_pad_oe_n & $past(inf_mask)) == $past(inf_mask);
  endproperty
  a_in_force: assert property (p_in_force) else $error("forced input driven");
endmodule

bind dpio_top dpio_top_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .first_pad_out(first_pad_out),
  .first_pad_oe_n(first_pad_oe_n), .second_pad_oe_n(second_pad_oe_n),
  .first_dig_in(first_dig_in), .first_ccp_out_en(first_ccp_out_en),
  .first_serial_out_en(first_serial_out_en), .first_other_out_en(first_other_out_en),
  .first_periph_out(first_periph_out), .first_periph_in_force(first_periph_in_force),
  .first_lcd_seg_en(first_lcd_seg_en), .first_lcd_seg_val(first_lcd_seg_val),
  .first_lcd_com_en(first_lcd_com_en), .first_lcd_com_val(first_lcd_com_val)
);

`default_nettype wire

// ### verification/dpio_pad_model.sv
`timescale 1ns/10ps
`default_nettype none

module dpio_pad_model (
  // Device side
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  // Outside driver
  input  wire logic [7:0] ext_drive,
  output logic      [7:0] pad_in
);
  // pin level
  // Released pins follow the outside driver, no pull-ups
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = pad_oe_n[i] ? ext_drive[i] : pad_out[i];
    end
  end
endmodule

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpio_cfg.svh"

module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, rtc_out, err;
  logic [3:0]  ext_addr;
  logic [7:0]  paddr, f_ccp, f_ser, f_oth, f_pout, f_pin, s_pen, s_pout, s_pin;
  logic [7:0]  f_seg_en, f_seg_val, f_com_en, f_com_val, s_seg_en, s_seg_val, f_ext, s_ext;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  wire  [7:0]  f_out, f_oe_n, f_in, s_out, s_oe_n, s_in, f_dig, s_dig;
  int          error_cnt = 0;
  int          n_compared = 0;

  dpio_top #(.PKG_VARIANT(2)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_pad_in(f_in), .first_pad_out(f_out), .first_pad_oe_n(f_oe_n),
    .second_pad_in(s_in), .second_pad_out(s_out), .second_pad_oe_n(s_oe_n),
    .first_dig_in(f_dig), .second_dig_in(s_dig),
    .first_ccp_out_en(f_ccp), .first_serial_out_en(f_ser), .first_other_out_en(f_oth),
    .first_periph_out(f_pout), .first_periph_in_force(f_pin),
    .second_periph_out_en(s_pen), .second_periph_out(s_pout), .second_periph_in_force(s_pin),
    .first_lcd_seg_en(f_seg_en), .first_lcd_seg_val(f_seg_val),
    .first_lcd_com_en(f_com_en), .first_lcd_com_val(f_com_val),
    .second_lcd_seg_en(s_seg_en), .second_lcd_seg_val(s_seg_val),
    .clock_calendar_output(rtc_out), .ext_bus_upper_address(ext_addr)
  );
  dpio_pad_model u_first (.pad_out(f_out), .pad_oe_n(f_oe_n), .ext_drive(f_ext), .pad_in(f_in));
  dpio_pad_model u_second (.pad_out(s_out), .pad_oe_n(s_oe_n), .ext_drive(s_ext), .pad_in(s_in));

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is sampled high
  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No local limit: only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Covers the two-flop sync plus output flop
  task automatic settle();
    repeat (5) @(posedge pclk);
    #1;
  endtask

  task automatic t_reset();
    #1;
    chk(f_oe_n, 8'hFF);
    settle();
    chk(f_dig, 8'h80);
    rdc(`DPIO_OFF_FIRST_DIR, 32'h0000_00FF);
    rdc(`DPIO_OFF_SECOND_DIR, 32'h0000_00FF);
    rdc(`DPIO_OFF_ANALOG, 32'h0000_FF1F);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_dir();
    wr(`DPIO_OFF_FIRST_LATCH, 32'hA5);
    wr(`DPIO_OFF_FIRST_DIR, 32'h0F);
    settle();
    chk(f_oe_n, 8'h0F);
    chk(f_out & 8'hF0, 8'hA0);
    chk(f_dig, 8'hA0);
    wr(`DPIO_OFF_ANALOG, 32'h0000_FF00);
    settle();
    chk(f_dig, 8'hAC);
    rdc(`DPIO_OFF_FIRST_DATA, 32'hAC);
    wr(`DPIO_OFF_FIRST_DATA, 32'h5A);
    rdc(`DPIO_OFF_FIRST_LATCH, 32'h5A);
    rdc(`DPIO_OFF_FIRST_DIR, 32'h0F);
    $display("t_dir done");
  endtask

  task automatic t_second();
    wr(`DPIO_OFF_SECOND_LATCH, 32'h3C);
    wr(`DPIO_OFF_SECOND_DIR, 32'h00);
    settle();
    chk(s_oe_n, 8'h00);
    chk(s_out, 8'h3C);
    chk(s_dig, 8'h0C);
    ext_addr <= 4'h9;
    wr(`DPIO_OFF_SECOND_DIR, 32'hFF);
    wr(`DPIO_OFF_CTRL, 32'h8);
    settle();
    chk(s_oe_n, 8'hF0);
    chk(s_out & 8'h0F, 8'h09);
    s_pen <= 8'h10;
    s_pout <= 8'h10;
    s_pin <= 8'h20;
    settle();
    chk(s_oe_n & 8'h30, 8'h20);
    chk(s_out & 8'h10, 8'h10);
    {s_pen, s_pout, s_pin} <= '0;
    $display("t_second done");
  endtask

  task automatic t_override();
    wr(`DPIO_OFF_FIRST_DIR, 32'h7F);
    wr(`DPIO_OFF_CTRL, 32'h7);
    rtc_out <= 1'b1;
    f_ccp <= 8'h20;
    f_ser <= 8'h08;
    f_oth <= 8'h40;
    f_pout <= 8'h48;
    f_pin <= 8'h80;
    settle();
    chk(f_oe_n & 8'hF8, 8'h88);
    chk(f_out & 8'h70, 8'h50);
    rdc(`DPIO_OFF_FIRST_DIR, 32'h7F);
    f_pout <= 8'h40;
    settle();
    chk(f_oe_n & 8'h08, 8'h00);
    {f_ccp, f_ser, f_oth, f_pin, rtc_out} <= '0;
    wr(`DPIO_OFF_CTRL, 32'h0);
    $display("t_override done");
  endtask

  task automatic t_lcd();
    wr(`DPIO_OFF_FIRST_DIR, 32'h00);
    f_seg_en <= 8'h03;
    f_seg_val <= 8'h01;
    f_com_en <= 8'h0C;
    f_com_val <= 8'h04;
    f_oth <= 8'h0C;
    f_pout <= 8'h08;
    s_seg_en <= 8'h80;
    s_seg_val <= 8'h80;
    settle();
    chk(f_out & 8'h0F, 8'h05);
    chk(f_oe_n & 8'h0F, 8'h00);
    chk(f_dig & 8'h03, 8'h00);
    chk(s_out & 8'h80, 8'h80);
    $display("t_lcd done");
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #20000;
    error_cnt++;
    final_report();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, rtc_out, ext_addr} = '0;
    {f_ccp, f_ser, f_oth, f_pout, f_pin, s_pen, s_pout, s_pin} = '0;
    {f_seg_en, f_seg_val, f_com_en, f_com_val, s_seg_en, s_seg_val} = '0;
    f_ext = 8'h8C;
    s_ext = 8'h00;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_dir();
    t_second();
    t_override();
    t_lcd();
    final_report();
  end
endmodule

`default_nettype wire
